/* hw/cpu_decode_pkg.sv */
// Constants and carrier types of the operand address decoder
package cpu_decode_pkg;
    // ****************************
    // Register offsets
    // ****************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_INDEX_X = 8'h0C;
    localparam logic [7:0] OFF_INDEX_Y = 8'h10;
    localparam logic [7:0] OFF_STACK = 8'h14;
    localparam logic [7:0] OFF_PCNT = 8'h18;
    localparam logic [7:0] OFF_FLAGS = 8'h1C;
    localparam logic [7:0] OFF_QUEUE = 8'h20;
    localparam logic [7:0] OFF_QTAIL = 8'h24;
    localparam logic [7:0] OFF_MODE = 8'h28;
    localparam logic [7:0] OFF_EA = 8'h2C;
    // ****************************
    // Fields and reset values
    // ****************************
    localparam int CTRL_START = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR = 2;
    localparam int ST_IND = 3;
    localparam int ST_PAGE = 4;
    localparam int ST_LEN = 5;
    localparam int MODE_WIDE = 3;
    localparam int QTAIL_CNT = 8;
    localparam int FLAG_S = 7;
    localparam int FLAG_X = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_I = 4;
    localparam logic [7:0] FLAGS_RST = 8'hD0;
    localparam logic [15:0] VECTOR_RST = 16'hFFFE;
    localparam logic [7:0] PAGE2_PREFIX = 8'h18;
    localparam logic [2:0] QUEUE_MIN = 3'h3;
    // ****************************
    // Addressing modes and codes
    // ****************************
    localparam logic [2:0] MODE_REGISTER_ONLY = 3'h0;
    localparam logic [2:0] MODE_LITERAL = 3'h1;
    localparam logic [2:0] MODE_DIRECT = 3'h2;
    localparam logic [2:0] MODE_FULL_ADDRESS = 3'h3;
    localparam logic [2:0] MODE_RELATIVE = 3'h4;
    localparam logic [2:0] MODE_INDEXED = 3'h5;
    localparam logic [1:0] RR_X = 2'h0;
    localparam logic [1:0] RR_Y = 2'h1;
    localparam logic [1:0] RR_STACK = 2'h2;
    localparam logic [1:0] RR_PROG = 2'h3;
    localparam logic [1:0] AA_A = 2'h0;
    localparam logic [1:0] AA_B = 2'h1;
    localparam logic [1:0] AA_D = 2'h2;
    localparam logic [1:0] AA_D_IND = 2'h3;
    // ****************************
    // Types
    // ****************************
    typedef enum logic [2:0] {
        ST_VEC_HI, ST_VEC_LO, ST_IDLE, ST_PTR_HI, ST_PTR_LO
    } state_e;
    typedef struct packed {
        logic [7:0] acc_a;
        logic [7:0] acc_b;
        logic [15:0] idx_x;
        logic [15:0] idx_y;
        logic [15:0] stack_pointer;
        logic [15:0] program_counter;
        logic [7:0] flag_register;
    } regs_s;
    typedef struct packed {
        logic [15:0] ea;
        logic [1:0] ext_len;
        logic indirect;
        logic wb_en;
        logic [1:0] wb_rr;
        logic [15:0] wb_val;
    } idx_s;
    typedef struct packed {
        state_e st;
        regs_s regs;
        logic [39:0] queue;
        logic [2:0] qcount;
        logic [3:0] mode;
        logic [15:0] ea;
        logic [2:0] len;
        logic ind;
        logic page2;
        logic done;
        logic err;
        logic ack;
        logic [7:0] ptr_hi;
        logic [15:0] mem_addr;
        logic [31:0] rdat;
    } state_s;
endpackage : cpu_decode_pkg

/* hw/idx_postbyte_decode.sv */
// Indexed postbyte decoder: base, offset, indirection, writeback
`timescale 1ns/1ps
module idx_postbyte_decode (
    input wire logic [7:0] postbyte,
    input wire logic [15:0] full_address_mode,
    input wire cpu_decode_pkg::regs_s regs,
    input wire logic [15:0] pc_after,
    output cpu_decode_pkg::idx_s res
);
    logic [1:0] rr;
    logic [15:0] base;
    logic [15:0] adj;
    logic [15:0] stepped;
    logic [15:0] dacc;

    always_comb
    begin
        res = '0;
        dacc = {regs.acc_a, regs.acc_b};
        // All-ones prefix reuses the program counter auto-adjust space
        rr = (!postbyte[5] || postbyte[7:5] != 3'h7)
            ? postbyte[7:6] : postbyte[4:3];
        if (postbyte[7:5] == 3'h7 && !postbyte[2] && !postbyte[1])
            res.ext_len = 2'h1;
        else if (postbyte[7:5] == 3'h7 && !postbyte[2])
            res.ext_len = 2'h2;
        unique case (rr)
            cpu_decode_pkg::RR_X: base = regs.idx_x;
            cpu_decode_pkg::RR_Y: base = regs.idx_y;
            cpu_decode_pkg::RR_STACK: base = regs.stack_pointer;
            cpu_decode_pkg::RR_PROG: base = pc_after
                + {14'h0000, res.ext_len};
        endcase
        adj = postbyte[3] ? {{12{1'b1}}, postbyte[3:0]}
            : {12'h000, postbyte[3:0]} + 16'h0001;
        stepped = base + adj;
        res.wb_rr = rr;
        if (!postbyte[5])
            res.ea = base + {{11{postbyte[4]}}, postbyte[4:0]};
        else if (postbyte[7:5] != 3'h7)
        begin
            res.ea = postbyte[4] ? base : stepped;
            res.wb_en = 1'b1;
            res.wb_val = stepped;
        end
        else if (!postbyte[2])
        begin
            if (!postbyte[1])
                res.ea = base + {{8{postbyte[0]}}, full_address_mode[15:8]};
            else
                res.ea = base + full_address_mode;
            res.indirect = postbyte[1] & postbyte[0];
        end
        else
        begin
            unique case (postbyte[1:0])
                cpu_decode_pkg::AA_A:
                    res.ea = base + {8'h00, regs.acc_a};
                cpu_decode_pkg::AA_B:
                    res.ea = base + {8'h00, regs.acc_b};
                cpu_decode_pkg::AA_D: res.ea = base + dacc;
                cpu_decode_pkg::AA_D_IND:
                begin
                    res.ea = base + dacc;
                    res.indirect = 1'b1;
                end
            endcase
        end
    end
endmodule : idx_postbyte_decode

/* hw/cpu_operand_address_decoder.sv */
// Operand address decoder with working registers and Wishbone slave
`timescale 1ns/1ps
// Summary of operation
// - Two 8-bit accumulators, also read together as one 16-bit double.
// - Indexed address is index register plus 5/9/16-bit constant or acc.
// - Stack pointer marks last used slot and serves as indexed base.
// - Program counter holds next instruction; base except in auto-adjust.
// - Flag register: five result flags, two masks, one stop-disable bit.
// - Out of reset fetch start vector with masks and stop-disable set.
// - Words are big-endian byte pairs, no alignment restriction.
// - At least three queued code bytes must be present to decode.
// - Working registers are not in the memory map.
// - Literal operand comes from the stream, one or two bytes.
// - Direct mode uses one byte as low address, high byte zero.
// - Full address is 16 bits; relative adds offset to program counter.
// - Postbyte rr0nnnnn adds signed 5-bit offset to chosen base.
// - Postbyte 111rr0zs gives 9-bit or 16-bit constant offset.
// - Postbyte 111rr011 reads a pointer at base plus 16-bit offset.
// - Postbyte rr1pnnnn pre or post adjusts X, Y or stack by 1..8.
// - Postbyte 111rr1aa adds unsigned A, B or D to the base.
// - Postbyte 111rr111 reads a pointer at base plus D.
// - Indexed form is opcode, postbyte, zero to two extension bytes.
// - Opcodes are one byte; prefix 18 selects the second page.
// - Postbytes and extension bytes follow opcodes as the form needs.
module cpu_operand_address_decoder #(
    parameter logic [15:0] VECTOR_ADDR = cpu_decode_pkg::VECTOR_RST
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack
);
    // ****************************
    // State and decode terms
    // ****************************
    cpu_decode_pkg::state_s s;
    cpu_decode_pkg::state_s n;
    cpu_decode_pkg::idx_s ix;
    logic [31:0] rd_word;
    logic [31:0] mask;
    logic [31:0] wd;
    logic wr;
    logic go;
    logic [39:0] qs;
    logic [15:0] opnd_addr;
    logic [2:0] ops_len;
    logic [2:0] len_tot;
    logic [15:0] dec_ea;
    logic dec_ind;
    logic ok;

    assign wr = cyc_i & stb_i & we_i & ~s.ack;
    assign mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
        {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign wd = (rd_word & ~mask) | (dat_i & mask);
    assign go = wr && adr_i == cpu_decode_pkg::OFF_CTRL
        && sel_i[0] && dat_i[cpu_decode_pkg::CTRL_START]
        && s.st == cpu_decode_pkg::ST_IDLE;
    // Second page prefix shifts the rest of the queue by one
    assign qs = (s.queue[39:32] == cpu_decode_pkg::PAGE2_PREFIX)
        ? {s.queue[31:0], 8'h00} : s.queue;
    assign opnd_addr = s.regs.program_counter + 16'h0001
        + {15'h0000, s.queue[39:32] == cpu_decode_pkg::PAGE2_PREFIX};
    assign len_tot = ops_len + 3'h1
        + {2'h0, s.queue[39:32] == cpu_decode_pkg::PAGE2_PREFIX};
    assign ok = s.qcount >= cpu_decode_pkg::QUEUE_MIN
        && s.qcount >= len_tot;
    assign ack_o = s.ack;
    // Read data rides in the state word, captured with the ack edge
    assign dat_o = s.rdat;
    assign mem_addr = s.mem_addr;
    assign mem_req = s.st != cpu_decode_pkg::ST_IDLE;

    idx_postbyte_decode u_idx (
        .postbyte(qs[31:24]),
        .full_address_mode(qs[23:8]),
        .regs(s.regs),
        .pc_after(opnd_addr + 16'h0001),
        .res(ix)
    );

    // ****************************
    // Address per mode
    // ****************************
    always_comb
    begin
        ops_len = 3'h0;
        dec_ea = 16'h0000;
        dec_ind = 1'b0;
        unique case (s.mode[2:0])
            cpu_decode_pkg::MODE_LITERAL:
            begin
                ops_len = s.mode[cpu_decode_pkg::MODE_WIDE]
                    ? 3'h2 : 3'h1;
                dec_ea = opnd_addr;
            end
            cpu_decode_pkg::MODE_DIRECT:
            begin
                ops_len = 3'h1;
                dec_ea = {8'h00, qs[31:24]};
            end
            cpu_decode_pkg::MODE_FULL_ADDRESS:
            begin
                ops_len = 3'h2;
                dec_ea = qs[31:16];
            end
            cpu_decode_pkg::MODE_RELATIVE:
            begin
                ops_len = s.mode[cpu_decode_pkg::MODE_WIDE]
                    ? 3'h2 : 3'h1;
                dec_ea = opnd_addr + {13'h0000, ops_len}
                    + (s.mode[cpu_decode_pkg::MODE_WIDE] ? qs[31:16]
                    : {{8{qs[31]}}, qs[31:24]});
            end
            cpu_decode_pkg::MODE_INDEXED:
            begin
                ops_len = 3'h1 + {1'b0, ix.ext_len};
                dec_ea = ix.ea;
                dec_ind = ix.indirect;
            end
            default:
            begin
                ops_len = 3'h0;
                dec_ea = 16'h0000;
            end
        endcase
    end

    // ****************************
    // Register read mux
    // ****************************
    // Working registers sit on this port only, never in memory space
    always_comb
    begin
        unique case (adr_i)
            cpu_decode_pkg::OFF_STATUS:
                rd_word = {24'h000000, s.len, s.page2, s.ind, s.err,
                    s.done, s.st != cpu_decode_pkg::ST_IDLE};
            cpu_decode_pkg::OFF_ACC:
                rd_word = {16'h0000, s.regs.acc_a, s.regs.acc_b};
            cpu_decode_pkg::OFF_INDEX_X:
                rd_word = {16'h0000, s.regs.idx_x};
            cpu_decode_pkg::OFF_INDEX_Y:
                rd_word = {16'h0000, s.regs.idx_y};
            cpu_decode_pkg::OFF_STACK:
                rd_word = {16'h0000, s.regs.stack_pointer};
            cpu_decode_pkg::OFF_PCNT:
                rd_word = {16'h0000, s.regs.program_counter};
            cpu_decode_pkg::OFF_FLAGS:
                rd_word = {24'h000000, s.regs.flag_register};
            cpu_decode_pkg::OFF_QUEUE:
                rd_word = s.queue[39:8];
            cpu_decode_pkg::OFF_QTAIL:
                rd_word = {21'h000000, s.qcount, s.queue[7:0]};
            cpu_decode_pkg::OFF_MODE:
                rd_word = {28'h0000000, s.mode};
            cpu_decode_pkg::OFF_EA:
                rd_word = {16'h0000, s.ea};
            default: rd_word = 32'h00000000;
        endcase
    end

    // ****************************
    // Next state
    // ****************************
    always_comb
    begin
        n = s;
        n.ack = cyc_i & stb_i & ~s.ack;
        n.rdat = rd_word;
        // Register writes only while idle, so decode writeback never races
        if (wr && s.st == cpu_decode_pkg::ST_IDLE)
        begin
            unique case (adr_i)
                cpu_decode_pkg::OFF_ACC:
                    {n.regs.acc_a, n.regs.acc_b} = wd[15:0];
                cpu_decode_pkg::OFF_INDEX_X: n.regs.idx_x = wd[15:0];
                cpu_decode_pkg::OFF_INDEX_Y: n.regs.idx_y = wd[15:0];
                cpu_decode_pkg::OFF_STACK:
                    n.regs.stack_pointer = wd[15:0];
                cpu_decode_pkg::OFF_PCNT:
                    n.regs.program_counter = wd[15:0];
                // Half carry is kept for decimal adjust only
                cpu_decode_pkg::OFF_FLAGS:
                    n.regs.flag_register = wd[7:0];
                cpu_decode_pkg::OFF_QUEUE: n.queue[39:8] = wd;
                cpu_decode_pkg::OFF_QTAIL:
                begin
                    n.queue[7:0] = wd[7:0];
                    n.qcount = wd[10:8];
                end
                cpu_decode_pkg::OFF_MODE: n.mode = wd[3:0];
                default: n.mode = s.mode;
            endcase
        end
        if (go)
        begin
            n.done = ok;
            n.err = ~ok;
            n.page2 = s.queue[39:32] == cpu_decode_pkg::PAGE2_PREFIX;
            n.len = len_tot;
            n.ind = ok & dec_ind;
            if (ok)
            begin
                n.ea = dec_ea;
                n.regs.program_counter = s.regs.program_counter
                    + {13'h0000, len_tot};
                if (s.mode[2:0] == cpu_decode_pkg::MODE_INDEXED
                    && ix.wb_en)
                begin
                    unique case (ix.wb_rr)
                        cpu_decode_pkg::RR_X:
                            n.regs.idx_x = ix.wb_val;
                        cpu_decode_pkg::RR_Y:
                            n.regs.idx_y = ix.wb_val;
                        default:
                            n.regs.stack_pointer = ix.wb_val;
                    endcase
                end
                if (dec_ind)
                begin
                    n.done = 1'b0;
                    n.mem_addr = dec_ea;
                    n.st = cpu_decode_pkg::ST_PTR_HI;
                end
            end
        end
        // High byte first, low byte at the next address
        if (mem_ack)
        begin
            unique case (s.st)
                cpu_decode_pkg::ST_VEC_HI, cpu_decode_pkg::ST_PTR_HI:
                begin
                    n.ptr_hi = mem_rdata;
                    n.mem_addr = s.mem_addr + 16'h0001;
                    n.st = s.st == cpu_decode_pkg::ST_VEC_HI
                        ? cpu_decode_pkg::ST_VEC_LO
                        : cpu_decode_pkg::ST_PTR_LO;
                end
                cpu_decode_pkg::ST_VEC_LO:
                begin
                    n.regs.program_counter = {s.ptr_hi, mem_rdata};
                    n.st = cpu_decode_pkg::ST_IDLE;
                end
                cpu_decode_pkg::ST_PTR_LO:
                begin
                    n.ea = {s.ptr_hi, mem_rdata};
                    n.done = 1'b1;
                    n.st = cpu_decode_pkg::ST_IDLE;
                end
                cpu_decode_pkg::ST_IDLE: n.st = s.st;
            endcase
        end
    end

    // ****************************
    // State register
    // ****************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.st <= cpu_decode_pkg::ST_VEC_HI;
            s.mem_addr <= VECTOR_ADDR;
            s.regs.flag_register <= cpu_decode_pkg::FLAGS_RST;
        end
        else
        begin
            s <= n;
        end
    end

    // ****************************
    // Checks
    // ****************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_reset_masks: assert property (
        $rose(rst_n) |-> s.regs.flag_register[cpu_decode_pkg::FLAG_S]
            && s.regs.flag_register[cpu_decode_pkg::FLAG_X]
            && s.regs.flag_register[cpu_decode_pkg::FLAG_I]
            && s.st == cpu_decode_pkg::ST_VEC_HI)
        else $error("reset state wrong");
    chk_pc_advance: assert property (
        go && ok |=> s.regs.program_counter
            == $past(s.regs.program_counter) + {13'h0000, $past(len_tot)})
        else $error("pc not advanced by length");
    chk_short_queue: assert property (
        go && s.qcount < cpu_decode_pkg::QUEUE_MIN
            |=> s.err && $stable(s.regs.program_counter))
        else $error("short queue accepted");
    chk_direct_page: assert property (
        go && ok && s.mode[2:0] == cpu_decode_pkg::MODE_DIRECT
            |=> s.ea == {8'h00, $past(qs[31:24])})
        else $error("direct address wrong");
    chk_full_addr: assert property (
        go && ok && s.mode[2:0] == cpu_decode_pkg::MODE_FULL_ADDRESS
            |=> s.ea == $past(qs[31:16]))
        else $error("extended address wrong");
    chk_short_offset: assert property (
        go && ok && s.mode[2:0] == cpu_decode_pkg::MODE_INDEXED
            && !qs[29] && qs[31:30] == cpu_decode_pkg::RR_X
            |=> s.ea == $past(s.regs.idx_x) + {{11{$past(qs[28])}},
                $past(qs[28:24])})
        else $error("5-bit offset wrong");
    chk_ptr_order: assert property (
        s.st == cpu_decode_pkg::ST_PTR_HI && mem_ack
            |=> s.st == cpu_decode_pkg::ST_PTR_LO
            && mem_addr == $past(mem_addr) + 16'h0001)
        else $error("pointer byte order wrong");
    chk_indirect_go: assert property (
        go && ok && dec_ind
            |=> s.st == cpu_decode_pkg::ST_PTR_HI && mem_req && !s.done)
        else $error("indirect fetch not started");
    chk_page_len: assert property (
        go && ok && s.mode[2:0] == cpu_decode_pkg::MODE_REGISTER_ONLY
            && s.queue[39:32] == cpu_decode_pkg::PAGE2_PREFIX
            |=> s.len == 3'h2 && s.page2)
        else $error("page prefix length wrong");
endmodule : cpu_operand_address_decoder

/* test/mem_model.sv */
// Program and data memory model on the core's byte read port
`timescale 1ns/1ps
module mem_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    logic slow_reg;
    logic [1:0] wait_reg;
    // ****
    // Answer logic
    // ****
    // Alternates prompt and slow answers; data toggles outside answers
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
            wait_reg <= 2'h0;
            slow_reg <= 1'b0;
        end
        else if (mem_req && !mem_ack && wait_reg == {slow_reg, slow_reg})
        begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5;
            wait_reg <= 2'h0;
            slow_reg <= ~slow_reg;
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack)
                wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule : mem_model

/* test/testbench.sv */
// Self-checking bench of the operand address decoder
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] P = cpu_decode_pkg::OFF_PCNT;
    localparam logic [7:0] X = cpu_decode_pkg::OFF_INDEX_X;
    localparam logic [7:0] Y = cpu_decode_pkg::OFF_INDEX_Y;
    localparam logic [7:0] S = cpu_decode_pkg::OFF_STACK;
    localparam logic [7:0] ST = cpu_decode_pkg::OFF_STATUS;
    logic mclk, rst_n, cyc, stb, we, ack, mem_req, mem_ack;
    logic [7:0] adr, mem_rdata;
    logic [3:0] sel;
    logic [15:0] mem_addr;
    logic [31:0] dat, rd, r;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    cpu_operand_address_decoder dut_u (
        .mclk(mclk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(rd), .ack_o(ack),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack)
    );
    mem_model mem_u (
        .mclk(mclk), .rst_n(rst_n), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
    );
    // ****
    // Helpers
    // ****
    function automatic logic [15:0] pw(input logic [15:0] a);
        logic [15:0] b;
        b = a + 16'h1;
        return {a[7:0] ^ a[15:8] ^ 8'hA5, b[7:0] ^ b[15:8] ^ 8'hA5};
    endfunction : pw
    task automatic complete_run;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Holds the request until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        @(posedge mclk);
        while (ack !== 1'b1)
            @(posedge mclk);
        r = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask : wr
    task automatic wait_idle;
        int n;
        n = 0;
        wb(1'b0, ST, 32'h0, 4'hF);
        while (r[0] !== 1'b0 && n < 60)
        begin
            wb(1'b0, ST, 32'h0, 4'hF);
            n++;
        end
        chk("busy", 16'h0, {15'h0, r[0]});
    endtask : wait_idle
    // f holds error, indirect and length; o names a register to read, v its expected value
    task automatic dec(input logic [39:0] q, input int c,
                       input int m, input logic [4:0] f,
                       input logic [15:0] ea, input logic [7:0] o,
                       input logic [15:0] v);
        wr(P, 32'h1000);
        wr(X, 32'h2000);
        wr(Y, 32'h3000);
        wr(S, 32'h4000);
        wr(cpu_decode_pkg::OFF_ACC, 32'h8090);
        wr(cpu_decode_pkg::OFF_QUEUE, q[39:8]);
        wr(cpu_decode_pkg::OFF_QTAIL, {21'h0, c[2:0], q[7:0]});
        wr(cpu_decode_pkg::OFF_MODE, {28'h0, m[3:0]});
        wr(cpu_decode_pkg::OFF_CTRL, 32'h1);
        wait_idle();
        chk("error", {15'h0, f[4]}, {15'h0, r[2]});
        if (!f[4])
            chk("status", {11'h0, f[2:0], q[39:32] == 8'h18, f[3]},
                {11'h0, r[7:3]});
        if (!f[4] && m[2:0] != 3'h0)
        begin
            wb(1'b0, cpu_decode_pkg::OFF_EA, 32'h0, 4'hF);
            chk("ea", ea, r[15:0]);
        end
        wb(1'b0, o, 32'h0, 4'hF);
        chk("register", v, r[15:0]);
    endtask : dec
    // ****
    // Clock, timeout and main sequence
    // ****
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // A hang in any wait ends here rather than running forever
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            complete_run();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dat = 32'h0;
        sel = 4'h0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        wait_idle();
        wb(1'b0, P, 32'h0, 4'hF);
        chk("vector", pw(cpu_decode_pkg::VECTOR_RST), r[15:0]);
        wb(1'b0, cpu_decode_pkg::OFF_FLAGS, 32'h0, 4'hF);
        chk("flags", 16'h00D0, r[15:0]);
        wb(1'b0, 8'h40, 32'h0, 4'hF);
        chk("unmapped", 16'h0, r[15:0]);
        wr(X, 32'h2000);
        wb(1'b1, X, 32'h123456FF, 4'h1);
        wb(1'b0, X, 32'h0, 4'hF);
        chk("lane", 16'h20FF, r[15:0]);
        dec(40'hA610000000, 3, 5, 5'h02, 16'h1FF0, P, 16'h1002);
        dec(40'hA6CF000000, 3, 5, 5'h02, 16'h1011, P, 16'h1002);
        dec(40'hA6E9000000, 3, 5, 5'h03, 16'h2F00, P, 16'h1003);
        dec(40'hA6F2123400, 4, 5, 5'h04, 16'h5234, P, 16'h1004);
        dec(40'hA6E4000000, 3, 5, 5'h02, 16'h2080, P, 16'h1002);
        dec(40'hA6ED000000, 3, 5, 5'h02, 16'h3090, P, 16'h1002);
        dec(40'hA6F6000000, 3, 5, 5'h02, 16'hC090, P, 16'h1002);
        dec(40'hA620000000, 3, 5, 5'h02, 16'h2001, X, 16'h2001);
        dec(40'hA67F000000, 3, 5, 5'h02, 16'h3000, Y, 16'h2FFF);
        dec(40'hA6A8000000, 3, 5, 5'h02, 16'h3FF8, S, 16'h3FF8);
        dec(40'hA6E3001000, 4, 5, 5'h0C, pw(16'h2010), P, 16'h1004);
        dec(40'hA6E7000000, 3, 5, 5'h0A, pw(16'hA090), P, 16'h1002);
        dec(40'h18A6000000, 3, 5, 5'h03, 16'h2000, P, 16'h1003);
        dec(40'h1887000000, 3, 0, 5'h02, 16'h0, P, 16'h1002);
        dec(40'hA6F2123400, 3, 5, 5'h10, 16'h0, P, 16'h1000);
        dec(40'hA610000000, 2, 5, 5'h10, 16'h0, P, 16'h1000);
        dec(40'h8642000000, 3, 1, 5'h02, 16'h1001, P, 16'h1002);
        dec(40'hCC12340000, 3, 9, 5'h03, 16'h1001, P, 16'h1003);
        dec(40'h9655000000, 3, 2, 5'h02, 16'h0055, P, 16'h1002);
        dec(40'hB6ABCD0000, 3, 3, 5'h03, 16'hABCD, P, 16'h1003);
        dec(40'h20FE000000, 3, 4, 5'h02, 16'h1000, P, 16'h1002);
        dec(40'h2001000000, 3, 12, 5'h03, 16'h1103, P, 16'h1003);
        dec(40'h8700000000, 3, 0, 5'h01, 16'h0, P, 16'h1001);
        complete_run();
    end
endmodule : testbench
